// ---- core/backlash_compensation.sv ----
// backlash compensation: parameter registers, direction tracking and position offset
`timescale 1ns/1ns
`include "blc_map.svh"

// Contract
// - while enabled, every movement is corrected automatically with no extra command; a reversal during a running ramp keeps the old target
// - only jog, profile position, homing and sequence abs/add/rel/ref moves compensate
// - backlash amount is 32 bits, accepts 0 to 2147483647
// - amount and time writes accepted only while power stage disabled
// - new amount and time take effect at next power stage enable
// - time 0 to 16383 ms, default 0; 0 is instant, else spread
// - mode 0 off, 1 on after up move, 2 on after down move, immediate
module backlash_compensation (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // parameter access port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [11:0] regAddr,
  input wire logic [31:0] regWdata,
  output logic [31:0] regRdata,
  output logic regAck,
  output logic regErr,
  // drive state
  input wire logic powerStageOn,
  input wire blc_pkg::blc_op_t opMode,
  // movement from the profile generator
  input wire logic moveStart,
  input wire logic moveDirDown,
  input wire logic signed [31:0] refPosition,
  // compensated position to the control loop
  output logic signed [32:0] compPosition,
  output logic signed [32:0] compOffset,
  output logic compActive,
  output logic compBusy,
  output logic lastDirDown
);

  // ****************************************
  // parameter registers
  // ****************************************
  logic [15:0] mode_r;
  logic [31:0] amount_r;
  logic [15:0] time_r;
  logic [31:0] amountAct_r;
  logic [15:0] timeAct_r;
  logic powerOn_r;
  logic lastDown_r;
  logic [31:0] rdata_r;
  logic ack_r;
  logic err_r;
  logic signed [32:0] compPos_r;
  logic [15:0] mode_nxt;
  logic [31:0] amount_nxt;
  logic [15:0] time_nxt;
  logic lastDown_nxt;

  // ****************************************
  // register access port
  // ****************************************
  // address decode and write qualification
  wire hitMode = (regAddr == `BLC_OFS_MODE);
  wire hitAmount = (regAddr == `BLC_OFS_AMOUNT);
  wire hitTime = (regAddr == `BLC_OFS_TIME);
  wire hitAny = hitMode | hitAmount | hitTime;
  wire stageOff = !powerStageOn;
  // the mode word is 16 bits wide; a write with upper bits set is refused like a bad code
  wire modeOk = (regWdata[15:0] <= 16'h0002) && (regWdata[31:16] == 16'h0000);
  wire amountOk = (regWdata <= `BLC_AMOUNT_MAX);
  wire timeOk = (regWdata[15:0] <= `BLC_TIME_MAX) && (regWdata[31:16] == 16'h0000);
  wire wrMode = regWrite && hitMode && modeOk;
  wire wrAmount = regWrite && hitAmount && amountOk && stageOff;
  wire wrTime = regWrite && hitTime && timeOk && stageOff;
  wire wrOk = wrMode | wrAmount | wrTime;
  // a refused write shows as an error answer; the stored value is untouched
  wire wrBad = regWrite && !wrOk;
  // an unmapped read answers zero data together with the error flag
  wire rdBad = regRead && !hitAny;

  // read mux
  wire [31:0] rdMux = hitMode ? {16'h0000, mode_r} :
                      hitAmount ? amount_r :
                      hitTime ? {16'h0000, time_r} : 32'h00000000;

  // next values; a refused write leaves the stored value as it was
  assign mode_nxt = wrMode ? regWdata[15:0] : mode_r;
  assign amount_nxt = wrAmount ? regWdata : amount_r;
  assign time_nxt = wrTime ? regWdata[15:0] : time_r;

  // written registers; mode acts at once, no power stage condition
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_r <= `BLC_MODE_RST;
      amount_r <= `BLC_AMOUNT_RST;
      time_r <= `BLC_TIME_RST;
    end else begin
      mode_r <= mode_nxt;
      amount_r <= amount_nxt;
      time_r <= time_nxt;
    end
  end

  // access answer, one cycle after the strobe
  // every strobe is answered, so a master never waits on a missing acknowledge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_r <= 32'h00000000;
      ack_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      ack_r <= regWrite | regRead;
      err_r <= wrBad | rdBad;
      if (regRead) rdata_r <= rdMux;
    end
  end

  assign regRdata = rdata_r;
  assign regAck = ack_r;
  assign regErr = err_r;

  // ****************************************
  // activation of parameters at power stage enable
  // ****************************************
  // amount and time writes are refused while the stage is on, so the working set cannot change mid-move
  wire enableEdge = powerStageOn && !powerOn_r;

  // working copies are loaded only on the enable edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      powerOn_r <= 1'b0;
      amountAct_r <= `BLC_AMOUNT_RST;
      timeAct_r <= `BLC_TIME_RST;
    end else begin
      powerOn_r <= powerStageOn;
      if (enableEdge) begin
        amountAct_r <= amount_r;
        timeAct_r <= time_r;
      end
    end
  end

  // ****************************************
  // direction tracking and offset request
  // ****************************************
  // mode decode; a changed mode acts from the cycle after its write
  wire modeOn = (mode_r == blc_pkg::BLC_ON_AFTER_UP_MOVE) ||
                (mode_r == blc_pkg::BLC_ON_AFTER_DOWN_MOVE);
  wire modeWrOn = wrMode && (regWdata[15:0] != 16'h0000);
  // only operating modes that carry target positions take compensation
  wire opAllowed = (opMode == blc_pkg::BLC_OP_JOG) ||
                   (opMode == blc_pkg::BLC_OP_PROFILE_POS) ||
                   (opMode == blc_pkg::BLC_OP_HOMING) ||
                   (opMode == blc_pkg::BLC_OP_SEQ_ABS) ||
                   (opMode == blc_pkg::BLC_OP_SEQ_ADD) ||
                   (opMode == blc_pkg::BLC_OP_SEQ_REL) ||
                   (opMode == blc_pkg::BLC_OP_SEQ_REF);
  wire compEnable = modeOn && opAllowed && powerStageOn;
  wire reversal = moveStart && (moveDirDown != lastDown_r);
  // the starting direction is only as good as the preparatory move
  wire takeStep = compEnable && reversal;
  // limitation: a reversal that lands while a ramp runs only moves the tracked
  // direction; the running ramp still ends on the target it started with

  // last direction: seeded by a mode 1 or 2 write, then followed on each move;
  // such a mode write in the same cycle as a move wins, as the controller states it
  wire modeSeedDown = (regWdata[15:0] == blc_pkg::BLC_ON_AFTER_DOWN_MOVE);
  assign lastDown_nxt = modeWrOn ? modeSeedDown :
                        moveStart ? moveDirDown : lastDown_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lastDown_r <= 1'b0;
    end else begin
      lastDown_r <= lastDown_nxt;
    end
  end

  // ****************************************
  // offset ramp
  // ****************************************
  // offset target: up side carries zero, down side carries minus the amount
  blc_ramp_if rampIf ();
  wire signed [32:0] amountS = $signed({1'b0, amountAct_r});
  // with the mode off a leftover offset is walked back to zero on the working time
  wire returnHome = !modeOn && (rampIf.offset != 33'h000000000);
  wire toDownSide = modeOn && moveDirDown;
  assign rampIf.start = takeStep || returnHome;
  assign rampIf.target = toDownSide ? -amountS : 33'h000000000;
  assign rampIf.timeMs = timeAct_r;

  // one ramp serves both the reversal steps and the return to zero
  blc_ramp uRamp (
    .clk(clk),
    .rst_n(rst_n),
    .rampIf(rampIf)
  );

  // ****************************************
  // position output
  // ****************************************
  // registered compensated position for the control loop
  // reference and offset of the same edge are added, so the sum is one cycle late
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      compPos_r <= 33'h000000000;
    end else begin
      compPos_r <= $signed({refPosition[31], refPosition}) + rampIf.offset;
    end
  end

  // ****************************************
  // status outputs
  // ****************************************
  // offset and busy come straight from the ramp's registers
  assign compPosition = compPos_r;
  assign compOffset = rampIf.offset;
  assign compActive = compEnable;
  assign compBusy = rampIf.busy;
  assign lastDirDown = lastDown_r;

endmodule // backlash_compensation

// ---- core/blc_map.svh ----
// register offsets, field limits, reset values and timing counts for backlash compensation
`ifndef BLC_MAP_SVH
`define BLC_MAP_SVH

// ****************************************
// register offsets
// ****************************************
`define BLC_OFS_MODE 12'h682
`define BLC_OFS_AMOUNT 12'h684
`define BLC_OFS_TIME 12'h688

// ****************************************
// field limits and reset values
// ****************************************
`define BLC_AMOUNT_MAX 32'h7FFFFFFF
`define BLC_TIME_MAX 16'h3FFF
`define BLC_TIME_RST 16'h0000
`define BLC_MODE_RST 16'h0000
`define BLC_AMOUNT_RST 32'h00000000

// ****************************************
// timing: one millisecond at 20 MHz
// ****************************************
`define BLC_CLK_HZ 20000000
`define BLC_MS_PER_S 1000
`define BLC_CYC_PER_MS (`BLC_CLK_HZ / `BLC_MS_PER_S)

`endif

// ---- core/blc_pkg.sv ----
// types shared by the backlash compensation modules
package blc_pkg;

  // mode field encodings
  typedef enum logic [15:0] {
    BLC_OFF = 16'h0000,
    BLC_ON_AFTER_UP_MOVE = 16'h0001,
    BLC_ON_AFTER_DOWN_MOVE = 16'h0002
  } blc_mode_t;

  // operating modes of the drive seen by this block
  typedef enum logic [3:0] {
    BLC_OP_NONE = 4'h0,
    BLC_OP_JOG = 4'h1,
    BLC_OP_PROFILE_POS = 4'h2,
    BLC_OP_HOMING = 4'h3,
    BLC_OP_SEQ_ABS = 4'h4,
    BLC_OP_SEQ_ADD = 4'h5,
    BLC_OP_SEQ_REL = 4'h6,
    BLC_OP_SEQ_REF = 4'h7,
    BLC_OP_PROFILE_VEL = 4'h8,
    BLC_OP_PROFILE_TRQ = 4'h9,
    BLC_OP_SEQ_VEL = 4'hA
  } blc_op_t;

  // ramp sequencer states, gray along idle-ramp-done
  typedef enum logic [1:0] {
    BLC_ST_IDLE = 2'b00,
    BLC_ST_RAMP = 2'b01,
    BLC_ST_DONE = 2'b11
  } blc_state_t;

endpackage

// ---- core/blc_ramp_if.sv ----
// handshake between the compensation core and its ramp generator
`timescale 1ns/1ns
interface blc_ramp_if;
  logic start;
  logic signed [32:0] target;
  logic [15:0] timeMs;
  logic signed [32:0] offset;
  logic busy;

  modport core (output start, output target, output timeMs, input offset, input busy);
  modport ramp (input start, input target, input timeMs, output offset, output busy);
endinterface

// ---- core/blc_ramp.sv ----
// ramp generator that walks the backlash offset to its target over a set time
`timescale 1ns/1ns
`include "blc_map.svh"
module blc_ramp (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link to the core
  blc_ramp_if.ramp rampIf
);

  localparam logic [15:0] CYC_PER_MS = 16'(`BLC_CYC_PER_MS);

  logic signed [32:0] offset_r;
  logic signed [32:0] target_r;
  logic signed [32:0] startOfs_r;
  logic [15:0] msTotal_r;
  logic [15:0] msCount_r;
  logic [15:0] cycCount_r;
  blc_pkg::blc_state_t state_r;
  logic msTick;
  logic lastMs;
  logic signed [65:0] span;
  logic signed [32:0] stepOfs;

  // millisecond tick and linear interpolation of the offset
  assign msTick = (cycCount_r == CYC_PER_MS - 16'h0001);
  assign lastMs = (msCount_r + 16'h0001 >= msTotal_r);
  assign span = 66'(target_r - startOfs_r) * 66'($signed({17'h00000, msCount_r + 16'h0001}));
  assign stepOfs = startOfs_r + 33'(span / 66'($signed({50'h0, msTotal_r})));
  assign rampIf.offset = offset_r;
  assign rampIf.busy = (state_r == blc_pkg::BLC_ST_RAMP);

  // sequencer: zero time jumps at once, otherwise one step per millisecond
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= blc_pkg::BLC_ST_IDLE;
      offset_r <= 33'h000000000;
      target_r <= 33'h000000000;
      startOfs_r <= 33'h000000000;
      msTotal_r <= 16'h0000;
      msCount_r <= 16'h0000;
      cycCount_r <= 16'h0000;
    end else begin
      case (state_r)
        blc_pkg::BLC_ST_IDLE, blc_pkg::BLC_ST_DONE: begin
          if (rampIf.start) begin
            target_r <= rampIf.target;
            startOfs_r <= offset_r;
            msTotal_r <= rampIf.timeMs;
            msCount_r <= 16'h0000;
            cycCount_r <= 16'h0000;
            if (rampIf.timeMs == 16'h0000) begin
              offset_r <= rampIf.target;
              state_r <= blc_pkg::BLC_ST_DONE;
            end else begin
              state_r <= blc_pkg::BLC_ST_RAMP;
            end
          end
        end
        blc_pkg::BLC_ST_RAMP: begin
          cycCount_r <= msTick ? 16'h0000 : cycCount_r + 16'h0001;
          if (msTick) begin
            offset_r <= lastMs ? target_r : stepOfs;
            msCount_r <= msCount_r + 16'h0001;
            if (lastMs) begin
              state_r <= blc_pkg::BLC_ST_DONE;
            end
          end
        end
        default: begin
          state_r <= blc_pkg::BLC_ST_IDLE;
        end
      endcase
    end
  end

endmodule // blc_ramp

// ---- dv/blc_motor_model.sv ----
// motor and load side model: issues movements and the reference position
`timescale 1ns/1ns
module blc_motor_model (
  // clock
  input wire logic clk,
  // movement toward the block
  output logic moveStart,
  output logic moveDirDown,
  output logic signed [31:0] refPosition
);
  // idle until the bench asks for a move
  initial begin
    moveStart = 1'b0;
    moveDirDown = 1'b0;
    refPosition = 32'sh0;
  end
  // one move; the direction line is flipped afterwards so a stale value is never trusted
  task move(input logic down);
    @(posedge clk) #5;
    moveStart = 1'b1;
    moveDirDown = down;
    refPosition = refPosition + (down ? -32'sh100 : 32'sh100);
    @(posedge clk) #5;
    moveStart = 1'b0;
    moveDirDown = ~down;
  endtask
endmodule // blc_motor_model

// ---- dv/blc_asserts.sv ----
// concurrent checks on the backlash compensation ports
`timescale 1ns/1ns
module blc_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // parameter port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [11:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regAck,
  input wire logic regErr,
  // drive state and motion
  input wire logic powerStageOn,
  input wire blc_pkg::blc_op_t opMode,
  input wire logic moveStart,
  input wire logic moveDirDown,
  input wire logic signed [31:0] refPosition,
  input wire logic signed [32:0] compPosition,
  input wire logic signed [32:0] compOffset,
  input wire logic compActive,
  input wire logic compBusy,
  input wire logic lastDirDown
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence sReq;
    regWrite || regRead;
  endsequence
  sequence sWr(a, c);
    regWrite && regAddr == a && c;
  endsequence
  a_ack_follows: assert property (sReq |=> regAck) else $error("no ack");
  a_ack_cause: assert property (regAck |-> $past(regWrite) || $past(regRead))
    else $error("stray ack");
  a_locked_write: assert property (sWr(12'h684, powerStageOn) |=> regErr)
    else $error("amount write taken while powered");
  a_amount_range: assert property (sWr(12'h684, regWdata[31]) |=> regErr)
    else $error("amount over range taken");
  a_time_range: assert property (sWr(12'h688, regWdata > 32'h3FFF) |=> regErr)
    else $error("time over range taken");
  a_mode_range: assert property (sWr(12'h682, regWdata > 32'h2) |=> regErr)
    else $error("bad mode taken");
  a_op_gate: assert property (compActive |-> powerStageOn && opMode >= blc_pkg::BLC_OP_JOG
    && opMode <= blc_pkg::BLC_OP_SEQ_REF) else $error("active in wrong mode");
  a_pos_sum: assert property (compPosition == $past(refPosition) + $past(compOffset))
    else $error("compensated position wrong");
  a_same_dir: assert property (moveStart && compActive && !compBusy
    && moveDirDown == lastDirDown |=> $stable(compOffset)) else $error("offset moved");
endmodule // blc_asserts
bind backlash_compensation blc_asserts chk_u (.clk(clk), .rst_n(rst_n), .regWrite(regWrite),
  .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regAck(regAck),
  .regErr(regErr), .powerStageOn(powerStageOn), .opMode(opMode), .moveStart(moveStart),
  .moveDirDown(moveDirDown), .refPosition(refPosition), .compPosition(compPosition),
  .compOffset(compOffset), .compActive(compActive), .compBusy(compBusy),
  .lastDirDown(lastDirDown));

// ---- dv/backlash_compensation_tb.sv ----
// self-checking bench for backlash compensation
`timescale 1ns/1ns
`include "blc_map.svh"
module backlash_compensation_tb;
  logic clk = 1'b0;
  logic rst_n;
  logic regWrite;
  logic regRead;
  logic [11:0] regAddr;
  logic [31:0] regWdata;
  logic [31:0] regRdata;
  logic regAck;
  logic regErr;
  logic powerStageOn;
  blc_pkg::blc_op_t opMode;
  logic moveStart;
  logic moveDirDown;
  logic signed [31:0] refPosition;
  logic signed [32:0] compPosition;
  logic signed [32:0] compOffset;
  logic compActive;
  logic compBusy;
  logic lastDirDown;
  int errors = 0;
  int checksDone = 0;
  int cyc = 0;
  int n;
  logic [32:0] amt;
  always #25 clk = ~clk;
  backlash_compensation dut_u (.clk(clk), .rst_n(rst_n), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .regAck(regAck), .regErr(regErr), .powerStageOn(powerStageOn), .opMode(opMode),
    .moveStart(moveStart), .moveDirDown(moveDirDown), .refPosition(refPosition),
    .compPosition(compPosition), .compOffset(compOffset), .compActive(compActive),
    .compBusy(compBusy), .lastDirDown(lastDirDown));
  blc_motor_model mot_u (.clk(clk), .moveStart(moveStart), .moveDirDown(moveDirDown),
    .refPosition(refPosition));
  // ****
  // helpers
  // ****
  task check(input logic [32:0] seen, input logic [32:0] exp);
    checksDone++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // one access; strobe lasts one cycle, ack lands on the next
  task acc(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic err);
    @(posedge clk) #5;
    regWrite = wr;
    regRead = ~wr;
    regAddr = a;
    regWdata = d;
    @(posedge clk) #5;
    regWrite = 1'b0;
    regRead = 1'b0;
    check(regAck, 1'b1);
    check(regErr, err);
  endtask
  task power(input logic on);
    @(posedge clk) #5;
    powerStageOn = on;
  endtask
  function logic allowed(input blc_pkg::blc_op_t o);
    return o >= blc_pkg::BLC_OP_JOG && o <= blc_pkg::BLC_OP_SEQ_REF;
  endfunction
  task report_and_stop;
    if (errors == 0 && checksDone > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // hang guard, well above the single 1 ms ramp
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      report_and_stop();
    end
  end
  // ****
  // main sequence
  // ****
  initial begin
    rst_n = 1'b0;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 12'h000;
    regWdata = 32'h00000000;
    powerStageOn = 1'b0;
    opMode = blc_pkg::BLC_OP_NONE;
    void'($urandom(32'h75eada2a));
    repeat (20) @(posedge clk);
    #5 rst_n = 1'b1;
    acc(0, `BLC_OFS_TIME, 0, 0);
    check(regRdata, 0);
    acc(0, 12'h686, 0, 1);
    acc(1, `BLC_OFS_MODE, 32'h3, 1);
    acc(1, `BLC_OFS_MODE, 32'h00010001, 1);
    acc(1, `BLC_OFS_AMOUNT, 32'h80000000, 1);
    acc(1, `BLC_OFS_TIME, 32'h4000, 1);
    acc(1, `BLC_OFS_AMOUNT, 32'h7FFFFFFF, 0);
    acc(0, `BLC_OFS_AMOUNT, 0, 0);
    check(regRdata, 32'h7FFFFFFF);
    amt = 33'($urandom & 32'hFFFF) + 33'h1;
    acc(1, `BLC_OFS_AMOUNT, amt[31:0], 0);
    acc(1, `BLC_OFS_TIME, 0, 0);
    opMode = blc_pkg::BLC_OP_JOG;
    power(1);
    acc(1, `BLC_OFS_AMOUNT, 32'h5, 1);
    acc(0, `BLC_OFS_AMOUNT, 0, 0);
    check(regRdata, amt[31:0]);
    mot_u.move(0);
    acc(1, `BLC_OFS_MODE, 32'h1, 0);
    // every operating mode once, ending on a sequence reference move
    for (int i = 0; i < 11; i++) begin
      @(posedge clk) #5;
      opMode = blc_pkg::blc_op_t'((i + 8) % 11);
      #1 check(compActive, allowed(opMode));
    end
    mot_u.move(0);
    check(compOffset, 0);
    mot_u.move(1);
    check(compOffset, 33'h0 - amt);
    check(lastDirDown, 1'b1);
    @(posedge clk) #5;
    check(compPosition, 33'(refPosition) - amt);
    mot_u.move(1);
    check(compOffset, 33'h0 - amt);
    mot_u.move(0);
    check(compOffset, 0);
    // spread correction: new time only counts after the next enable
    power(0);
    acc(1, `BLC_OFS_TIME, 32'h1, 0);
    power(1);
    mot_u.move(1);
    check(compBusy, 1'b1);
    n = 0;
    while (compBusy === 1'b1 && n < 25000) begin
      @(posedge clk) #5;
      n++;
    end
    check(n > 19990 && n < 20010, 1'b1);
    check(compOffset, 33'h0 - amt);
    acc(1, `BLC_OFS_MODE, 32'h0, 0);
    check(compActive, 1'b0);
    report_and_stop();
  end
endmodule // backlash_compensation_tb
